//--- hw/relay_defs.svh
// constants, register map and field layout of the safety relay sequencer
// assumes: included by bare name by the package, the sequencer module and the bench
// Notes on behaviour
// - with the aux supply, reset loop and autoreset link strapped together the outputs come on as soon as inputs are met.
// - in pressure-mat mode the outputs may only come on while both mat channels are closed.
// - in pressure-mat mode a loaded mat or a short to the zero-volt return drops both output pairs and flashes the power lamp.
// - contactor test contacts sit in the reset loop and no start happens unless that loop is closed.
// - there are four normally-open outputs, two direct and two delayable, plus one normally-closed output following the direct pair.
// - the first indicator shows that the input conditions are met, whatever the reset state.
// - the second indicator is on only while both direct outputs are on.
// - the third indicator is on only while both delayed outputs are on.
// - three straps pick the delay, 0/0.5/1.0/1.5 s in the short variant and 0/1/2/3 s in the long one.
// - on a stop the delayed pair stays on for the chosen delay and then drops.
// - manual reset starts only after the reset input is seen closing and then opening again.
// - a new reset is taken only while all four outputs are confirmed off.
// - when inputs drop the direct pair drops at once and the delayed pair at once or after the delay.
// - after a trip both input channels must be seen open before a reset is taken.
`ifndef RELAY_DEFS_SVH
`define RELAY_DEFS_SVH

// timing
`define CLK_HZ 25000000
`define MS_PER_S 1000
`define CLK_PER_MS (`CLK_HZ / `MS_PER_S)
`define RESET_MIN_MS 100
`define DELAY_STEP_SHORT_MS 500
`define DELAY_STEP_LONG_MS 1000
`define FLASH_HALF_MS 250
`define MS_W 12

// register byte offsets
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_IRQ_STAT 4'h8
`define OFS_IRQ_MASK 4'hC

// control fields
`define CTRL_RESET 4'h0
`define CTRL_LONG_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 3

// input modes
`define MODE_SINGLE 3'h0
`define MODE_DUAL_NO 3'h1
`define MODE_NO_NC 3'h2
`define MODE_ZERO_V 3'h3
`define MODE_MAT 3'h4

// interrupt bits
`define IRQ_W 4
`define IRQ_START 0
`define IRQ_TRIP 1
`define IRQ_MAT 2
`define IRQ_REJECT 3
`define IRQ_RESET 4'h0

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hw/relay_pkg.sv
// types shared by the safety relay sequencer modules
// assumes: relay_defs.svh is on the include path
`include "relay_defs.svh"

package relay_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_PRESS, ST_RUN, ST_STOP} seq_state_t;
   typedef logic [`MS_W-1:0] ms_t;
endpackage

//--- hw/pin_sync.sv
// two-flop synchroniser for a vector of field inputs
// assumes: each bit is an independent slow level
`timescale 1ns/10ps

module pin_sync #(
   parameter int W = 1
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic [W-1:0] d, // asynchronous levels
   output logic [W-1:0] q // synchronised levels
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // first flop feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule

//--- hw/ms_timer.sv
// millisecond down-counter for the delayed output pair
// assumes: ms_tick is a one-cycle pulse once per millisecond
`timescale 1ns/10ps

module ms_timer (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic ms_tick, // one pulse per ms
   input wire logic load, // start a new delay
   input wire relay_pkg::ms_t load_ms, // delay length in ms
   output logic busy // delay still running
);
   import relay_pkg::*;

   ms_t cnt_reg;
   ms_t cnt_next;

   // load wins over counting
   always_comb begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = load_ms;
      end else if (ms_tick && cnt_reg != '0) begin
         cnt_next = cnt_reg - ms_t'(1);
      end
   end

   // register the count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign busy = (cnt_reg != '0);
endmodule

//--- hw/safety_relay_sequencer.sv
// sequencing logic of a safety relay with an axi4-lite register slave
// assumes: all field pins are asynchronous levels, high means contact closed
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "relay_defs.svh"

module safety_relay_sequencer #(
   parameter int CLK_PER_MS = `CLK_PER_MS
) (
   input wire logic aclk, // system clock, 25 MHz
   input wire logic aresetn, // sync reset, active low
   input wire logic positive_channel_a, // channel a, closed high
   input wire logic positive_channel_b, // channel b, closed high
   input wire logic inverted_channel, // nc channel, closed high
   input wire logic zero_volt_channel, // channel from 0 V, closed high
   input wire logic mat_short_sense, // short across channel a and return
   input wire logic reset_loop_input, // reset and test-contact loop
   input wire logic autoreset_link_input, // autoreset strap
   input wire logic delay_select_a, // delay strap a
   input wire logic delay_select_b, // delay strap b
   input wire logic delay_select_c, // delay strap c
   input wire logic [3:0] relay_off_fb, // high when relay confirmed off
   output logic [1:0] direct_out, // direct no pair
   output logic [1:0] delayed_out, // delayable no pair
   output logic nc_info_out, // nc contact of direct pair
   output logic inputs_ok_indicator, // inputs satisfied
   output logic direct_pair_on_indicator, // both direct on
   output logic delayed_pair_on_indicator, // both delayed on
   output logic power_led_out, // power lamp, flashes on mat fault
   output logic irq, // level interrupt
   input wire logic [3:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [3:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready // read data ready
);
   import relay_pkg::*;

   // synchronised pins
   logic [13:0] pins_s;
   logic ch_a, ch_b, ch_inv, ch_zv, short_s, loop_ok, auto_sel, sel_a, sel_b, sel_c;
   logic all_off;

   pin_sync #(.W(14)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({relay_off_fb, delay_select_c, delay_select_b, delay_select_a,
          autoreset_link_input, reset_loop_input, mat_short_sense,
          zero_volt_channel, inverted_channel, positive_channel_b,
          positive_channel_a}),
      .q(pins_s)
   );

   assign ch_a = pins_s[0];
   assign ch_b = pins_s[1];
   assign ch_inv = pins_s[2];
   assign ch_zv = pins_s[3];
   assign short_s = pins_s[4];
   assign loop_ok = pins_s[5];
   assign auto_sel = pins_s[6];
   assign sel_a = pins_s[7];
   assign sel_b = pins_s[8];
   assign sel_c = pins_s[9];
   // every relay must read released before a start
   assign all_off = &pins_s[13:10];

   // registers
   logic [3:0] ctrl_reg, ctrl_next;
   logic [`IRQ_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
   logic [2:0] mode;
   assign mode = ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];

   // millisecond tick and lamp flash from the single clock
   logic [15:0] div_reg, div_next;
   logic [7:0] flash_cnt_reg, flash_cnt_next;
   logic flash_reg, flash_next, ms_tick;
   assign ms_tick = (div_reg == 16'(CLK_PER_MS - 1));

   always_comb begin
      div_next = ms_tick ? 16'h0000 : div_reg + 16'h0001;
      flash_cnt_next = flash_cnt_reg;
      flash_next = flash_reg;
      if (ms_tick) begin
         if (flash_cnt_reg == 8'(`FLASH_HALF_MS - 1)) begin
            flash_cnt_next = 8'h00;
            flash_next = ~flash_reg;
         end else begin
            flash_cnt_next = flash_cnt_reg + 8'h01;
         end
      end
   end

   // input evaluation per mode
   logic inputs_ok, chan_open, mat_fault;
   always_comb begin
      mat_fault = 1'b0;
      case (mode)
         `MODE_DUAL_NO: begin
            inputs_ok = ch_a & ch_b;
            chan_open = ~ch_a & ~ch_b;
         end
         `MODE_NO_NC: begin
            inputs_ok = ch_a & ~ch_inv;
            chan_open = ~ch_a & ch_inv;
         end
         `MODE_ZERO_V: begin
            inputs_ok = ch_a & ch_zv;
            chan_open = ~ch_a & ~ch_zv;
         end
         `MODE_MAT: begin
            inputs_ok = ch_a & ch_zv & ~short_s;
            chan_open = ~ch_a & ~ch_zv;
            mat_fault = ~inputs_ok;
         end
         default: begin
            inputs_ok = ch_a;
            chan_open = ~ch_a;
         end
      endcase
   end

   // sequencer state
   seq_state_t state_reg, state_next;
   logic [6:0] press_reg, press_next;
   logic loop_prev_reg, open_seen_reg, open_seen_next;
   ms_t delay_ms_reg, delay_ms_next;
   logic timer_load, timer_busy, start_ok, ev_start, ev_trip, ev_reject;
   assign start_ok = inputs_ok & open_seen_reg & all_off;

   ms_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .ms_tick(ms_tick),
      .load(timer_load),
      .load_ms(delay_ms_reg),
      .busy(timer_busy)
   );

   // next state and strap sampling
   always_comb begin
      state_next = state_reg;
      press_next = press_reg;
      delay_ms_next = delay_ms_reg;
      timer_load = 1'b0;
      ev_start = 1'b0;
      ev_trip = 1'b0;
      ev_reject = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // straps read only while outputs are off
            if (sel_a) begin
               delay_ms_next = ctrl_reg[`CTRL_LONG_BIT] ? ms_t'(`DELAY_STEP_LONG_MS)
                  : ms_t'(`DELAY_STEP_SHORT_MS);
            end else if (sel_b) begin
               delay_ms_next = ctrl_reg[`CTRL_LONG_BIT] ? ms_t'(2 * `DELAY_STEP_LONG_MS)
                  : ms_t'(2 * `DELAY_STEP_SHORT_MS);
            end else if (sel_c) begin
               delay_ms_next = ctrl_reg[`CTRL_LONG_BIT] ? ms_t'(3 * `DELAY_STEP_LONG_MS)
                  : ms_t'(3 * `DELAY_STEP_SHORT_MS);
            end else begin
               delay_ms_next = '0;
            end
            if (auto_sel) begin
               if (start_ok && loop_ok) begin
                  state_next = ST_RUN;
                  ev_start = 1'b1;
               end
            end else if (loop_ok && !loop_prev_reg) begin
               state_next = ST_PRESS;
               press_next = 7'h00;
            end
         end
         ST_PRESS: begin
            if (ms_tick && press_reg != 7'(`RESET_MIN_MS)) begin
               press_next = press_reg + 7'h01;
            end
            if (auto_sel) begin
               state_next = ST_IDLE;
            end else if (!loop_ok) begin
               if (press_reg == 7'(`RESET_MIN_MS) && start_ok) begin
                  state_next = ST_RUN;
                  ev_start = 1'b1;
               end else begin
                  state_next = ST_IDLE;
                  ev_reject = 1'b1;
               end
            end
         end
         ST_RUN: begin
            if (!inputs_ok) begin
               ev_trip = 1'b1;
               if (mat_fault || delay_ms_reg == '0) begin
                  state_next = ST_IDLE;
               end else begin
                  state_next = ST_STOP;
                  timer_load = 1'b1;
               end
            end
         end
         ST_STOP: begin
            if (!timer_busy) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      open_seen_next = (state_next == ST_RUN) ? 1'b0 : (open_seen_reg | chan_open);
   end

   // output and indicator next values
   logic [1:0] direct_next, delayed_next;
   assign direct_next = (state_next == ST_RUN) ? 2'h3 : 2'h0;
   assign delayed_next = (state_next == ST_RUN || state_next == ST_STOP) ? 2'h3 : 2'h0;

   // axi4-lite slave state
   logic aw_pend_reg, aw_pend_next, w_pend_reg, w_pend_next;
   logic [3:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic wstrb0_reg, wstrb0_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next, status_word;
   logic do_write, mat_prev_reg;
   logic [`IRQ_W-1:0] events, w1c;

   assign s_axi_awready = ~aw_pend_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_pend_reg & ~bvalid_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign do_write = aw_pend_reg & w_pend_reg & ~bvalid_reg;

   assign status_word = {10'h000, delay_ms_reg, 1'b0, state_reg, loop_ok, auto_sel,
                         mat_fault, open_seen_reg, delayed_out[0], direct_out[0],
                         inputs_ok_indicator};

   assign events = {ev_reject, mat_fault & ~mat_prev_reg, ev_trip, ev_start};

   // bus next values, writes and sticky flags
   always_comb begin
      aw_pend_next = aw_pend_reg;
      w_pend_next = w_pend_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb0_next = wstrb0_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      ctrl_next = ctrl_reg;
      irq_mask_next = irq_mask_reg;
      w1c = '0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_pend_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_pend_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb0_next = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_pend_next = 1'b0;
         w_pend_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = `RESP_OKAY;
         case (awaddr_reg)
            `OFS_CTRL: if (wstrb0_reg) ctrl_next = wdata_reg[3:0];
            `OFS_STATUS: bresp_next = `RESP_OKAY;
            `OFS_IRQ_STAT: if (wstrb0_reg) w1c = wdata_reg[`IRQ_W-1:0];
            `OFS_IRQ_MASK: if (wstrb0_reg) irq_mask_next = wdata_reg[`IRQ_W-1:0];
            default: bresp_next = `RESP_SLVERR;
         endcase
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = `RESP_OKAY;
         case (s_axi_araddr)
            `OFS_CTRL: rdata_next = {28'h0000000, ctrl_reg};
            `OFS_STATUS: rdata_next = status_word;
            `OFS_IRQ_STAT: rdata_next = {28'h0000000, irq_stat_reg};
            `OFS_IRQ_MASK: rdata_next = {28'h0000000, irq_mask_reg};
            default: begin
               rdata_next = 32'h00000000;
               rresp_next = `RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      // a new event wins over a clear in the same cycle
      irq_stat_next = (irq_stat_reg & ~w1c) | events;
   end

   // register everything
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         press_reg <= 7'h00;
         loop_prev_reg <= 1'b1;
         open_seen_reg <= 1'b0;
         delay_ms_reg <= '0;
         div_reg <= 16'h0000;
         flash_cnt_reg <= 8'h00;
         flash_reg <= 1'b0;
         mat_prev_reg <= 1'b0;
         direct_out <= 2'h0;
         delayed_out <= 2'h0;
         nc_info_out <= 1'b1;
         inputs_ok_indicator <= 1'b0;
         direct_pair_on_indicator <= 1'b0;
         delayed_pair_on_indicator <= 1'b0;
         power_led_out <= 1'b1;
         irq <= 1'b0;
         ctrl_reg <= `CTRL_RESET;
         irq_stat_reg <= `IRQ_RESET;
         irq_mask_reg <= `IRQ_RESET;
         aw_pend_reg <= 1'b0;
         w_pend_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 32'h00000000;
         wstrb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= `RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else begin
         state_reg <= state_next;
         press_reg <= press_next;
         loop_prev_reg <= loop_ok;
         open_seen_reg <= open_seen_next;
         delay_ms_reg <= delay_ms_next;
         div_reg <= div_next;
         flash_cnt_reg <= flash_cnt_next;
         flash_reg <= flash_next;
         mat_prev_reg <= mat_fault;
         direct_out <= direct_next;
         delayed_out <= delayed_next;
         nc_info_out <= ~&direct_next;
         inputs_ok_indicator <= inputs_ok;
         direct_pair_on_indicator <= &direct_next;
         delayed_pair_on_indicator <= &delayed_next;
         power_led_out <= mat_fault ? flash_reg : 1'b1;
         irq <= |(irq_stat_next & irq_mask_next);
         ctrl_reg <= ctrl_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         aw_pend_reg <= aw_pend_next;
         w_pend_reg <= w_pend_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb0_reg <= wstrb0_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   // automatic reset starts the outputs one edge after the conditions
   property p_auto_start;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_IDLE && auto_sel && start_ok && loop_ok) |=> (direct_out == 2'h3);
   endproperty
   a_auto_start: assert property (p_auto_start) else $error("auto start missed");

   // a mat fault clears both output pairs at once
   property p_mat_drop;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_RUN && mat_fault) |=> (direct_out == 2'h0 && delayed_out == 2'h0);
   endproperty
   a_mat_drop: assert property (p_mat_drop) else $error("mat fault kept outputs");

   // open reset loop blocks a start
   property p_loop_needed;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg != ST_RUN && !loop_ok && !$past(loop_ok)) |=> (state_reg != ST_RUN);
   endproperty
   a_loop_needed: assert property (p_loop_needed) else $error("start with open loop");

   // pair indicators follow the outputs
   property p_ind_pairs;
      @(posedge aclk) disable iff (!aresetn)
      (direct_pair_on_indicator == (direct_out == 2'h3))
         && (delayed_pair_on_indicator == (delayed_out == 2'h3)) && (nc_info_out == !direct_out[0]);
   endproperty
   a_ind_pairs: assert property (p_ind_pairs) else $error("indicator mismatch");

   // delayed pair held while direct pair is off
   property p_delay_hold;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_RUN && !inputs_ok && !mat_fault && delay_ms_reg != '0)
         |=> (direct_out == 2'h0 && delayed_out == 2'h3) [*2];
   endproperty
   a_delay_hold: assert property (p_delay_hold) else $error("delay hold lost");

   // a press shorter than the minimum is refused
   property p_short_press;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_PRESS && !loop_ok && !auto_sel && press_reg < 7'(`RESET_MIN_MS))
         |=> (state_reg == ST_IDLE && direct_out == 2'h0);
   endproperty
   a_short_press: assert property (p_short_press) else $error("short press started");

   // direct pair drops one edge after the inputs
   property p_direct_drop;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_RUN && !inputs_ok) |=> (direct_out == 2'h0);
   endproperty
   a_direct_drop: assert property (p_direct_drop) else $error("direct pair held");

   // no start unless relays confirmed off and channels seen open
   property p_start_guard;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg != ST_RUN && (!all_off || !open_seen_reg)) |=> (state_reg != ST_RUN);
   endproperty
   a_start_guard: assert property (p_start_guard) else $error("start without guard");

   // strap value frozen while outputs are on
   property p_strap_hold;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_RUN || state_reg == ST_STOP) |=> $stable(delay_ms_reg);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("straps resampled");
endmodule

//--- tb/field_model.sv
// field side: reset button, contactor test contacts, relay feedback
// assumes: relays follow the coil outputs one clock later
`timescale 1ns/10ps

module field_model (
   input wire logic aclk, // system clock
   input wire logic btn, // button or autoreset strap
   input wire logic [1:0] direct_out, // direct coils
   input wire logic [1:0] delayed_out, // delayed coils
   output logic [3:0] relay_off_fb, // relays seen off
   output logic reset_loop_input // button with test contacts
);
   // relay armatures lag the coils by a clock
   initial relay_off_fb = 4'hF;
   always @(posedge aclk) begin
      relay_off_fb <= ~{delayed_out, direct_out};
   end
   // test contacts closed only while all contactors are released
   assign reset_loop_input = btn & (&relay_off_fb);
endmodule

//--- tb/safety_relay_sequencer_tb_top.sv
// bench: axi4-lite tasks and field stimulus for the relay sequencer
// assumes: 1 ms is shortened to CPMS clocks
`timescale 1ns/10ps
`include "relay_defs.svh"

module safety_relay_sequencer_tb_top;
   localparam int CPMS = 10;
   logic aclk, aresetn, positive_channel_a, positive_channel_b, inverted_channel;
   logic zero_volt_channel, mat_short_sense, reset_loop_input, autoreset_link_input, btn;
   logic delay_select_a, delay_select_b, delay_select_c, nc_info_out, inputs_ok_indicator;
   logic direct_pair_on_indicator, delayed_pair_on_indicator, power_led_out, irq;
   logic [1:0] direct_out, delayed_out, s_axi_bresp, s_axi_rresp;
   logic [3:0] relay_off_fb, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int error_cnt = 0, total_checks = 0, n;
   wire logic [6:0] outs = {direct_out, delayed_out, nc_info_out, direct_pair_on_indicator,
      delayed_pair_on_indicator};

   safety_relay_sequencer #(.CLK_PER_MS(CPMS)) i_safety_relay_sequencer (.*);
   field_model i_field_model (.*);

   // free-running system clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic final_report();
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask

   function automatic logic cond(input int w);
      case (w)
         0: return s_axi_bvalid;
         1: return s_axi_rvalid;
         2: return delayed_out == 2'h0;
         default: return power_led_out == 1'b0;
      endcase
   endfunction

   // bounded wait; releases address and data channels once taken
   task automatic wait_on(input int w);
      n = 0;
      while (cond(w) !== 1'b1) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         n++;
         if (n > 9000) begin
            error_cnt++;
            final_report();
         end
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      wait_on(0);
      s_axi_bready <= 1'b0;
      chk("bresp", `RESP_OKAY, s_axi_bresp);
      tick(1);
   endtask

   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wait_on(1);
      s_axi_rready <= 1'b0;
      chk("rresp rdata", e, {s_axi_rresp, s_axi_rdata});
      tick(1);
   endtask

   // main sequence: manual, automatic, mat mode, then dual channel
   initial begin
      {positive_channel_a, positive_channel_b, inverted_channel, zero_volt_channel} = 4'h0;
      {mat_short_sense, autoreset_link_input, btn, delay_select_b, delay_select_c} = 5'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00F;
      s_axi_wdata = 32'h0;
      delay_select_a = 1'b1;
      aresetn = 1'b0;
      tick(8);
      aresetn <= 1'b1;
      tick(4);
      chk("outs", 7'h04, outs);
      rd(`OFS_CTRL, 34'h0);
      rd(4'h2, {`RESP_SLVERR, 32'h0});
      wr(`OFS_IRQ_MASK, 32'hF);
      positive_channel_a <= 1'b1;
      tick(5);
      chk("inputs ok", 1'b1, inputs_ok_indicator);
      chk("outs", 7'h04, outs);
      btn <= 1'b1;
      tick(CPMS * 50);
      btn <= 1'b0;
      tick(5);
      chk("outs", 7'h04, outs);
      chk("irq", 1'b1, irq);
      wr(`OFS_IRQ_STAT, 32'h8);
      tick(2);
      chk("irq", 1'b0, irq);
      btn <= 1'b1;
      tick(CPMS * 110);
      btn <= 1'b0;
      tick(5);
      chk("outs", 7'h7B, outs);
      positive_channel_a <= 1'b0;
      tick(4);
      chk("outs", 7'h1D, outs);
      wait_on(2);
      chk("delay", 1'b1, n > CPMS * 490 && n < CPMS * 510);
      rd(`OFS_IRQ_STAT, 34'h3);
      delay_select_a <= 1'b0;
      autoreset_link_input <= 1'b1;
      btn <= 1'b1;
      tick(3);
      positive_channel_a <= 1'b1;
      tick(5);
      chk("outs", 7'h7B, outs);
      positive_channel_a <= 1'b0;
      tick(4);
      chk("outs", 7'h04, outs);
      wr(`OFS_CTRL, 32'h8);
      positive_channel_a <= 1'b1;
      tick(5);
      chk("outs", 7'h04, outs);
      zero_volt_channel <= 1'b1;
      tick(5);
      chk("outs", 7'h7B, outs);
      mat_short_sense <= 1'b1;
      tick(4);
      chk("outs", 7'h04, outs);
      wait_on(3);
      chk("flash", 1'b1, n <= CPMS * 251);
      // dual channel: no restart until both channels were seen open
      wr(`OFS_CTRL, 32'h2);
      positive_channel_b <= 1'b1;
      tick(5);
      chk("outs", 7'h04, outs);
      {positive_channel_a, positive_channel_b} <= 2'h0;
      tick(4);
      {positive_channel_a, positive_channel_b} <= 2'h3;
      tick(5);
      chk("outs", 7'h7B, outs);
      final_report();
   end
endmodule
